// File: ddc_dual_dac_control.sv
// dual dac control: avalon register slave, enable decode and two channels
`timescale 1ns/10ps

// What this block does
// - two eight-bit value registers, cleared on reset/standby
// - control register resets to 1F, also on standby
// - control bits four to zero read one, ignore writes
// - bit seven enables channel one convert and drive
// - bit six enables channel zero convert and drive
// - bit five couples conversion of both channels
// - both output enables zero disables all conversion
// - pin drive follows only own output enable
// - value write restarts that channel's conversion on the next clock edge after the write
// - output holds level until rewrite or disable
// - cleared output enable releases the pin
module ddc_dual_dac_control
  import ddc_pkg::*;
(
  input  wire logic                            core_clk_in,
  input  wire logic                            resetn_in,
  input  wire logic                            standby_in,
  input  wire logic [ddc_pkg::DDC_ADDR_W-1:0]  avs_address_in,
  input  wire logic                            avs_read_in,
  input  wire logic                            avs_write_in,
  input  wire logic [3:0]                      avs_byteenable_in,
  input  wire logic [31:0]                     avs_writedata_in,
  output logic      [31:0]                     avs_readdata_out,
  output logic                                 avs_waitrequest_out,
  output logic      [7:0]                      analog_out_ch0_out,
  output logic                                 analog_out_ch0_oe_out,
  output logic      [7:0]                      analog_out_ch1_out,
  output logic                                 analog_out_ch1_oe_out,
  output logic      [1:0]                      conv_en_out,
  output logic      [1:0]                      settled_out
);
  import ddc_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic [7:0]  value_ch0_q, value_ch0_d;
  logic [7:0]  value_ch1_q, value_ch1_d;
  logic        out_en_ch1_q, out_en_ch1_d;
  logic        out_en_ch0_q, out_en_ch0_d;
  logic        joint_conv_enable_q, joint_conv_enable_d;
  logic [1:0]  conv_en_q, conv_en_d;
  logic [1:0]  drive_en_q, drive_en_d;
  logic [1:0]  restart_q, restart_d;
  logic        standby_q, standby_d;
  logic        req;
  logic        wr_now;
  logic [15:0] index;
  logic        addr_low_ok;
  logic        hit_v0;
  logic        hit_v1;
  logic        hit_ctl;
  logic        hit_sta;
  logic        lane0_wr;
  logic [7:0]  control_rd;
  logic [7:0]  status_rd;
  logic [1:0]  ch_settled;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  assign req         = avs_read_in | avs_write_in;
  assign index       = avs_address_in[DDC_ADDR_W-1:2];
  assign addr_low_ok = (avs_address_in[1:0] == 2'h0);
  assign hit_v0      = addr_low_ok && (index == DDC_IDX_VALUE_CH0);
  assign hit_v1      = addr_low_ok && (index == DDC_IDX_VALUE_CH1);
  assign hit_ctl     = addr_low_ok && (index == DDC_IDX_CONTROL);
  assign hit_sta     = addr_low_ok && (index == DDC_IDX_STATUS);
  assign wr_now      = avs_write_in && ack_q && !standby_q;
  assign lane0_wr    = wr_now && avs_byteenable_in[0];

  // reserved control bits always read as one
  assign control_rd  = {out_en_ch1_q, out_en_ch0_q, joint_conv_enable_q, 5'h1F};
  assign status_rd   = {2'h0, drive_en_q, conv_en_q, ch_settled};

  // ---------------------------------------------------------------
  // bus handshake: request taken, answered one cycle later
  // ---------------------------------------------------------------
  always_comb begin
    ack_d   = req && !ack_q;
    rdata_d = rdata_q;
    if (req && !ack_q) begin
      rdata_d = 32'h0000_0000;
      if (hit_v0) begin
        rdata_d = {24'h00_0000, value_ch0_q};
      end else if (hit_v1) begin
        rdata_d = {24'h00_0000, value_ch1_q};
      end else if (hit_ctl) begin
        rdata_d = {24'h00_0000, control_rd};
      end else if (hit_sta) begin
        rdata_d = {24'h00_0000, status_rd};
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign avs_waitrequest_out = req && !ack_q;
  assign avs_readdata_out    = rdata_q;

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_comb begin
    value_ch0_d         = value_ch0_q;
    value_ch1_d         = value_ch1_q;
    out_en_ch1_d        = out_en_ch1_q;
    out_en_ch0_d        = out_en_ch0_q;
    joint_conv_enable_d = joint_conv_enable_q;
    restart_d           = 2'h0;
    standby_d           = standby_in;
    if (standby_in) begin
      value_ch0_d         = DDC_VALUE_RESET;
      value_ch1_d         = DDC_VALUE_RESET;
      out_en_ch1_d        = DDC_CONTROL_RESET[DDC_BIT_OUT_EN1];
      out_en_ch0_d        = DDC_CONTROL_RESET[DDC_BIT_OUT_EN0];
      joint_conv_enable_d = DDC_CONTROL_RESET[DDC_BIT_JOINT];
    end else if (lane0_wr) begin
      if (hit_v0) begin
        value_ch0_d  = avs_writedata_in[7:0];
        restart_d[0] = 1'b1;
      end
      if (hit_v1) begin
        value_ch1_d  = avs_writedata_in[7:0];
        restart_d[1] = 1'b1;
      end
      if (hit_ctl) begin
        out_en_ch1_d        = avs_writedata_in[DDC_BIT_OUT_EN1];
        out_en_ch0_d        = avs_writedata_in[DDC_BIT_OUT_EN0];
        joint_conv_enable_d = avs_writedata_in[DDC_BIT_JOINT];
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      value_ch0_q         <= DDC_VALUE_RESET;
      value_ch1_q         <= DDC_VALUE_RESET;
      out_en_ch1_q        <= DDC_CONTROL_RESET[DDC_BIT_OUT_EN1];
      out_en_ch0_q        <= DDC_CONTROL_RESET[DDC_BIT_OUT_EN0];
      joint_conv_enable_q <= DDC_CONTROL_RESET[DDC_BIT_JOINT];
      restart_q           <= 2'h0;
      standby_q           <= 1'b0;
    end else begin
      value_ch0_q         <= value_ch0_d;
      value_ch1_q         <= value_ch1_d;
      out_en_ch1_q        <= out_en_ch1_d;
      out_en_ch0_q        <= out_en_ch0_d;
      joint_conv_enable_q <= joint_conv_enable_d;
      restart_q           <= restart_d;
      standby_q           <= standby_d;
    end
  end

  // ---------------------------------------------------------------
  // enable decode, registered one clock after the control register
  // ---------------------------------------------------------------
  always_comb begin
    drive_en_d = {out_en_ch1_q, out_en_ch0_q};
    if (!out_en_ch1_q && !out_en_ch0_q) begin
      conv_en_d = 2'h0;
    end else if (joint_conv_enable_q) begin
      conv_en_d = 2'h3;
    end else begin
      conv_en_d = {out_en_ch1_q, out_en_ch0_q};
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      conv_en_q  <= 2'h0;
      drive_en_q <= 2'h0;
    end else begin
      conv_en_q  <= conv_en_d;
      drive_en_q <= drive_en_d;
    end
  end

  assign conv_en_out = conv_en_q;
  assign settled_out = ch_settled;

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  ddc_channel u_ch0 (
    .core_clk_in  (core_clk_in),
    .resetn_in    (resetn_in),
    .clear_in     (standby_q),
    .conv_en_in   (conv_en_q[0]),
    .restart_in   (restart_q[0]),
    .out_en_in    (drive_en_q[0]),
    .code_in      (value_ch0_q),
    .level_out    (analog_out_ch0_out),
    .level_oe_out (analog_out_ch0_oe_out),
    .settled_out  (ch_settled[0])
  );

  ddc_channel u_ch1 (
    .core_clk_in  (core_clk_in),
    .resetn_in    (resetn_in),
    .clear_in     (standby_q),
    .conv_en_in   (conv_en_q[1]),
    .restart_in   (restart_q[1]),
    .out_en_in    (drive_en_q[1]),
    .code_in      (value_ch1_q),
    .level_out    (analog_out_ch1_out),
    .level_oe_out (analog_out_ch1_oe_out),
    .settled_out  (ch_settled[1])
  );

endmodule // ddc_dual_dac_control

// File: ddc_pkg.sv
// constants, offsets and reset values of the dual dac control block
package ddc_pkg;

  // ---------------------------------------------------------------
  // register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [15:0] DDC_IDX_VALUE_CH0 = 16'hFFF8;
  localparam logic [15:0] DDC_IDX_VALUE_CH1 = 16'hFFF9;
  localparam logic [15:0] DDC_IDX_CONTROL   = 16'hFFFA;
  localparam logic [15:0] DDC_IDX_STATUS    = 16'hFFFB;
  localparam int unsigned DDC_ADDR_W        = 18;

  // ---------------------------------------------------------------
  // reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0]  DDC_VALUE_RESET   = 8'h00;
  localparam logic [7:0]  DDC_CONTROL_RESET = 8'h1F;
  localparam logic [7:0]  DDC_RSVD_MASK     = 8'h1F;
  localparam int unsigned DDC_BIT_OUT_EN1   = 7;
  localparam int unsigned DDC_BIT_OUT_EN0   = 6;
  localparam int unsigned DDC_BIT_JOINT     = 5;

  // ---------------------------------------------------------------
  // conversion timing
  // ---------------------------------------------------------------
  localparam int unsigned DDC_CLK_PERIOD_NS = 10;
  localparam int unsigned DDC_CONV_TIME_NS  = 10000;
  localparam int unsigned DDC_CONV_CYCLES   =
    (DDC_CONV_TIME_NS / DDC_CLK_PERIOD_NS < 1) ? 1 : DDC_CONV_TIME_NS / DDC_CLK_PERIOD_NS;
  localparam int unsigned DDC_CNT_W         = 10;
  localparam logic [DDC_CNT_W-1:0] DDC_CNT_LOAD = DDC_CNT_W'(DDC_CONV_CYCLES - 1);
  localparam logic [DDC_CNT_W-1:0] DDC_CNT_ZERO = '0;

  typedef enum logic [1:0] {
    DDC_CH_IDLE    = 2'b00,
    DDC_CH_CONVERT = 2'b01,
    DDC_CH_HOLD    = 2'b10
  } ddc_ch_state_t;

endpackage

// File: ddc_channel.sv
// one converter channel: conversion delay, held level and pin drive
`timescale 1ns/10ps
module ddc_channel
  import ddc_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       resetn_in,
  input  wire logic       clear_in,
  input  wire logic       conv_en_in,
  input  wire logic       restart_in,
  input  wire logic       out_en_in,
  input  wire logic [7:0] code_in,
  output logic      [7:0] level_out,
  output logic            level_oe_out,
  output logic            settled_out
);
  import ddc_pkg::*;

  ddc_ch_state_t        state_q, state_d;
  logic [DDC_CNT_W-1:0] cnt_q, cnt_d;
  logic [7:0]           held_q, held_d;
  logic                 oe_q, oe_d;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    held_d  = held_q;
    oe_d    = out_en_in;
    if (clear_in || !conv_en_in) begin
      state_d = DDC_CH_IDLE;
      cnt_d   = DDC_CNT_ZERO;
      held_d  = DDC_VALUE_RESET;
      oe_d    = 1'b0;
    end else if (restart_in) begin
      state_d = DDC_CH_CONVERT;
      cnt_d   = DDC_CNT_LOAD;
    end else begin
      case (state_q)
        DDC_CH_IDLE: begin
          state_d = DDC_CH_CONVERT;
          cnt_d   = DDC_CNT_LOAD;
        end
        DDC_CH_CONVERT: begin
          if (cnt_q == DDC_CNT_ZERO) begin
            state_d = DDC_CH_HOLD;
            held_d  = code_in;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        DDC_CH_HOLD: begin
          held_d = held_q;
        end
        default: begin
          state_d = DDC_CH_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= DDC_CH_IDLE;
      cnt_q   <= DDC_CNT_ZERO;
      held_q  <= DDC_VALUE_RESET;
      oe_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      held_q  <= held_d;
      oe_q    <= oe_d;
    end
  end

  assign level_out    = held_q;
  assign level_oe_out = oe_q;
  assign settled_out  = (state_q == DDC_CH_HOLD);

endmodule // ddc_channel

// File: ddc_checker.sv
// concurrent checks on the ports of the dual dac control block
`timescale 1ns/10ps
module ddc_checker
  import ddc_pkg::*;
(
  input wire logic                           core_clk_in,
  input wire logic                           resetn_in,
  input wire logic                           standby_in,
  input wire logic [ddc_pkg::DDC_ADDR_W-1:0] avs_address_in,
  input wire logic                           avs_read_in,
  input wire logic                           avs_write_in,
  input wire logic [31:0]                    avs_readdata_out,
  input wire logic                           avs_waitrequest_out,
  input wire logic [7:0]                     analog_out_ch0_out,
  input wire logic                           analog_out_ch0_oe_out,
  input wire logic                           analog_out_ch1_oe_out,
  input wire logic [1:0]                     conv_en_out,
  input wire logic [1:0]                     settled_out
);
  // ---------------------------------------------------------------
  // bus and enable checks
  // ---------------------------------------------------------------
  localparam logic [17:0] CTL_A = {DDC_IDX_CONTROL, 2'b00};
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_req; (avs_read_in || avs_write_in) && avs_waitrequest_out; endsequence
  sequence s_rd_ack; avs_read_in && !avs_waitrequest_out; endsequence
  a_wait_one: assert property (s_req |=> !avs_waitrequest_out)
    else $error("waitrequest held past one cycle");
  a_wait_first: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
    else $error("read answered without wait");
  a_rsvd_ones: assert property (s_rd_ack ##0 (avs_address_in == CTL_A) |->
    avs_readdata_out[4:0] == 5'h1F) else $error("reserved control bits not one");
  a_upper_zero: assert property (s_rd_ack |-> avs_readdata_out[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_oe_conv: assert property ((!analog_out_ch0_oe_out || $past(conv_en_out[0])) &&
    (!analog_out_ch1_oe_out || $past(conv_en_out[1]))) else $error("drive without convert");
  a_settle_conv: assert property ($rose(settled_out[0]) |-> $past(conv_en_out[0]))
    else $error("settled while conversion off");
  a_level_zero: assert property (!conv_en_out[0] [*3] |-> analog_out_ch0_out == 8'h00)
    else $error("level kept while conversion off");
  a_std_quiet: assert property (standby_in [*4] |-> conv_en_out == 2'b00 &&
    !analog_out_ch0_oe_out && !analog_out_ch1_oe_out) else $error("active in standby");
endmodule // ddc_checker

bind ddc_dual_dac_control ddc_checker ddc_checker_i (.core_clk_in, .resetn_in, .standby_in,
  .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out, .avs_waitrequest_out,
  .analog_out_ch0_out, .analog_out_ch0_oe_out, .analog_out_ch1_oe_out, .conv_en_out,
  .settled_out);

// File: ddc_dual_dac_control_test.sv
// self-checking bench for the dual dac control block
`timescale 1ns/10ps
module ddc_dual_dac_control_test;
  import ddc_pkg::*;
  // ---------------------------------------------------------------
  // signals, model and tasks
  // ---------------------------------------------------------------
  logic        clk, rst_n, stby, rd, wr, wait_req, oe0, oe1;
  logic [17:0] addr;
  logic [3:0]  be;
  logic [31:0] wdata, rdata;
  logic [7:0]  lvl0, lvl1, v;
  logic [1:0]  conv_en, settled;
  logic [17:0] ra[4];
  int          mreg[4];
  int          error_cnt, n_checks, ch;

  ddc_dual_dac_control ddc_dual_dac_control_i (.core_clk_in(clk), .resetn_in(rst_n),
    .standby_in(stby), .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_byteenable_in(be), .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req), .analog_out_ch0_out(lvl0), .analog_out_ch0_oe_out(oe0),
    .analog_out_ch1_out(lvl1), .analog_out_ch1_oe_out(oe1), .conv_en_out(conv_en),
    .settled_out(settled));

  always #5 clk = ~clk;

  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    rd <= !w; wr <= w; addr <= a; wdata <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0) begin
      chk(32'h0, 32'h1);
      final_report();
    end
    if (!w) chk(rdata, {24'h000000, mreg[ch][7:0]});
    rd <= 1'b0; wr <= 1'b0;
  endtask

  task automatic wait_lvl(input int c, input logic [7:0] e);
    int n;
    n = 0;
    while ((c ? lvl1 : lvl0) !== e && n < 1500) begin
      @(posedge clk);
      n++;
    end
    chk(c ? lvl1 : lvl0, e);
    if (n >= 1500) final_report();
  endtask

  task automatic put(input int c, input logic [7:0] d);
    ch = c;
    mreg[c] = (c == 2) ? (d | 8'h1F) : d;
    bus(1'b1, ra[c], d);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 0; rst_n = 0; stby = 0; rd = 0; wr = 0; be = 4'hF; addr = '0; wdata = '0;
    error_cnt = 0; n_checks = 0; mreg = '{0, 0, 31, 0};
    ra = '{{DDC_IDX_VALUE_CH0, 2'b00}, {DDC_IDX_VALUE_CH1, 2'b00},
           {DDC_IDX_CONTROL, 2'b00}, {DDC_IDX_STATUS, 2'b00}};
    void'($urandom(70));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    for (ch = 0; ch < 3; ch++) bus(1'b0, ra[ch], 8'h00);
    mreg[0] = 0; ch = 0;
    bus(1'b0, 18'h3FF00, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      put($urandom % 3, v);
      bus(1'b0, ra[ch], 8'h00);
    end
    for (int c = 0; c < 8; c++) begin
      put(2, 8'(c << 5));
      repeat (3) @(posedge clk);
      chk({oe1, oe0, conv_en}, {c[2], c[1], c[2] | (c[0] & c[1]), c[1] | (c[0] & c[2])});
    end
    v = $urandom;
    put(0, v);
    put(1, ~v);
    put(2, 8'hC0);
    wait_lvl(0, v);
    wait_lvl(1, ~v);
    repeat (50) @(posedge clk);
    chk(lvl0, v);
    chk({settled, conv_en}, 4'hF);
    ch = 3;
    mreg[3] = 8'h3F;
    bus(1'b0, ra[3], 8'h00);
    v = v ^ 8'h5A;
    put(0, v);
    wait_lvl(0, v);
    put(2, 8'h80);
    repeat (3) @(posedge clk);
    chk({oe1, oe0}, 2'b10);
    stby <= 1'b1;
    put(0, 8'hA5);
    repeat (5) @(posedge clk);
    stby <= 1'b0;
    mreg = '{0, 0, 31, 0};
    for (ch = 0; ch < 3; ch++) bus(1'b0, ra[ch], 8'h00);
    final_report();
  end
endmodule // ddc_dual_dac_control_test
